// file: logic/adcar_pkg.sv
package adcar_pkg;

   localparam int unsigned ADCAR_CLK_HZ = 50_000_000;

   // byte offsets as seen by the serial register engine
   localparam logic [7:0] ADCAR_OFF_THERM_LO   = 8'h45;
   localparam logic [7:0] ADCAR_OFF_CHG_HI     = 8'h46;
   localparam logic [7:0] ADCAR_OFF_CHG_LO     = 8'h47;
   localparam logic [7:0] ADCAR_OFF_AUX_HI     = 8'h48;
   localparam logic [7:0] ADCAR_OFF_AUX_LO     = 8'h49;
   localparam logic [7:0] ADCAR_OFF_VIN_HI     = 8'h4A;
   localparam logic [7:0] ADCAR_OFF_VIN_LO     = 8'h4B;
   localparam logic [7:0] ADCAR_OFF_SYS_HI     = 8'h4C;
   localparam logic [7:0] ADCAR_OFF_SYS_LO     = 8'h4D;
   localparam logic [7:0] ADCAR_OFF_IIN_HI     = 8'h4E;
   localparam logic [7:0] ADCAR_OFF_IIN_LO     = 8'h4F;
   localparam logic [7:0] ADCAR_OFF_ALM1_HI    = 8'h52;
   localparam logic [7:0] ADCAR_OFF_ALM1_LO    = 8'h53;
   localparam logic [7:0] ADCAR_OFF_ALM2_HI    = 8'h54;
   localparam logic [7:0] ADCAR_OFF_ALM2_LO    = 8'h55;

   localparam logic [7:0] ADCAR_RST_ALM1_HI    = 8'h23;
   localparam logic [7:0] ADCAR_RST_ALM1_LO    = 8'h20;
   localparam logic [7:0] ADCAR_RST_ALM2_HI    = 8'h38;
   localparam logic [7:0] ADCAR_RST_ALM2_LO    = 8'h90;
   localparam logic [7:0] ADCAR_RST_RESULT     = 8'h00;
   localparam logic [7:0] ADCAR_READ_UNMAPPED  = 8'h00;

   // low threshold register layout
   localparam int unsigned ADCAR_THR_NIB_MSB   = 7;
   localparam int unsigned ADCAR_THR_NIB_LSB   = 4;
   localparam int unsigned ADCAR_DIR_BIT       = 3;

   // result comparison window: upper twelve bits of sixteen
   localparam int unsigned ADCAR_CMP_MSB       = 15;
   localparam int unsigned ADCAR_CMP_LSB       = 4;

   typedef enum logic [2:0] {
      ADCAR_CH_OFF     = 3'h0,
      ADCAR_CH_AUX     = 3'h1,
      ADCAR_CH_THERM   = 3'h2,
      ADCAR_CH_BATT    = 3'h3,
      ADCAR_CH_CHARGE  = 3'h4,
      ADCAR_CH_VIN     = 3'h5,
      ADCAR_CH_SYS     = 3'h6,
      ADCAR_CH_IIN     = 3'h7
   } adcar_channel_t;

   function automatic logic [11:0] adcar_threshold(input logic [7:0] hi, input logic [7:0] lo);
      adcar_threshold = {hi, lo[ADCAR_THR_NIB_MSB:ADCAR_THR_NIB_LSB]};
   endfunction

endpackage

// file: logic/adcar_alarm_cmp.sv
`timescale 1ns/1ps

module adcar_alarm_cmp
   import adcar_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        conv_valid,
   input  wire logic [2:0]  conv_channel,
   input  wire logic [15:0] conv_data,
   input  wire logic [2:0]  channel_select,
   input  wire logic [11:0] threshold,
   input  wire logic        direction,
   output logic             alarm_event
);

   typedef struct packed {
      logic alarm_event;
   } adcar_cmp_state_t;

   adcar_cmp_state_t state;
   adcar_cmp_state_t next_state;

   logic [11:0] sample;
   logic        hit;

   always_comb begin
      next_state = state;
      sample     = conv_data[ADCAR_CMP_MSB:ADCAR_CMP_LSB];
      // strict compare: a result equal to the threshold never trips
      hit        = direction ? (sample > threshold) : (sample < threshold);
      next_state.alarm_event = conv_valid
                               && (channel_select != ADCAR_CH_OFF)
                               && (conv_channel == channel_select)
                               && hit;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign alarm_event = state.alarm_event;

endmodule

// file: logic/adcar_regs.sv
`timescale 1ns/1ps

// Behaviour
// - thermistor result low byte is readable, read-only, resets to 0x00.
// - charge current result high byte at 0x46, low byte at 0x47, read-only.
// - auxiliary input result high byte at 0x48, low byte at 0x49, read-only.
// - input voltage result high byte at 0x4A, low byte at 0x4B, read-only.
// - system rail result high byte at 0x4C, low byte at 0x4D, read-only.
// - input current result high byte at 0x4E, low byte at 0x4F, read-only.
// - alarm 1 threshold is 12 bits: byte at 0x52, nibble at 0x53 bits 7-4.
// - alarm 1 threshold resets to 0x23 high byte and 0x2 nibble.
// - alarm 1 direction bit 3: 0 trips below threshold, 1 above.
// - alarm 2 threshold is 12 bits: byte at 0x54, nibble at 0x55 bits 7-4.
// - alarm 2 threshold resets to 0x38 high byte and 0x9 nibble.
// - alarm 2 direction bit 3: 0 trips below threshold, 1 above.
// - channel select 0 disables an alarm; 1 to 7 pick one measured channel.
// - conversion trigger clears itself when any conversion completes.
module adcar_regs
   import adcar_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        conv_valid,
   input  wire logic [2:0]  conv_channel,
   input  wire logic [15:0] conv_data,
   input  wire logic        trigger_set,
   output logic             conversion_trigger,
   input  wire logic [2:0]  alarm1_channel_select,
   input  wire logic [2:0]  alarm2_channel_select,
   input  wire logic        alarm1_flag_clear,
   input  wire logic        alarm2_flag_clear,
   output logic             alarm1_event,
   output logic             alarm2_event,
   output logic             alarm1_flag,
   output logic             alarm2_flag,
   output logic [11:0]      alarm1_threshold,
   output logic [11:0]      alarm2_threshold,
   output logic             alarm1_direction,
   output logic             alarm2_direction
);

   localparam int unsigned NUM_SLOTS = 6;

   // result slots, one per stored channel
   localparam logic [2:0] SLOT_THERM  = 3'h0;
   localparam logic [2:0] SLOT_CHARGE = 3'h1;
   localparam logic [2:0] SLOT_AUX    = 3'h2;
   localparam logic [2:0] SLOT_VIN    = 3'h3;
   localparam logic [2:0] SLOT_SYS    = 3'h4;
   localparam logic [2:0] SLOT_IIN    = 3'h5;

   typedef struct packed {
      logic [NUM_SLOTS-1:0][15:0] result;
      logic [7:0]                 alarm1_threshold_high;
      logic [7:0]                 alarm1_threshold_low_polarity;
      logic [7:0]                 alarm2_threshold_high;
      logic [7:0]                 alarm2_threshold_low_polarity;
      logic [7:0]                 rdata;
      logic                       rvalid;
      logic                       trigger;
      logic                       flag1;
      logic                       flag2;
      logic [7:0]                 shadow_low;
      logic [2:0]                 shadow_slot;
      logic                       shadow_valid;
   } adcar_state_t;

   adcar_state_t state;
   adcar_state_t next_state;

   logic        cmp1_event;
   logic        cmp2_event;
   logic        slot_hit;
   logic [2:0]  slot_sel;
   logic [7:0]  read_byte;
   logic        hi_hit;
   logic        lo_hit;
   logic [2:0]  hi_slot;
   logic [2:0]  lo_slot;

   // channel code to storage slot; battery has no slot here
   function automatic logic [3:0] adcar_slot(input logic [2:0] channel);
      unique case (channel)
         ADCAR_CH_THERM: begin
            adcar_slot = {1'b1, SLOT_THERM};
         end
         ADCAR_CH_CHARGE: begin
            adcar_slot = {1'b1, SLOT_CHARGE};
         end
         ADCAR_CH_AUX: begin
            adcar_slot = {1'b1, SLOT_AUX};
         end
         ADCAR_CH_VIN: begin
            adcar_slot = {1'b1, SLOT_VIN};
         end
         ADCAR_CH_SYS: begin
            adcar_slot = {1'b1, SLOT_SYS};
         end
         ADCAR_CH_IIN: begin
            adcar_slot = {1'b1, SLOT_IIN};
         end
         default: begin
            adcar_slot = 4'h0;
         end
      endcase
   endfunction

   // high result offset to storage slot
   function automatic logic [3:0] adcar_high_slot(input logic [7:0] addr);
      unique case (addr)
         ADCAR_OFF_CHG_HI: begin
            adcar_high_slot = {1'b1, SLOT_CHARGE};
         end
         ADCAR_OFF_AUX_HI: begin
            adcar_high_slot = {1'b1, SLOT_AUX};
         end
         ADCAR_OFF_VIN_HI: begin
            adcar_high_slot = {1'b1, SLOT_VIN};
         end
         ADCAR_OFF_SYS_HI: begin
            adcar_high_slot = {1'b1, SLOT_SYS};
         end
         ADCAR_OFF_IIN_HI: begin
            adcar_high_slot = {1'b1, SLOT_IIN};
         end
         default: begin
            adcar_high_slot = 4'h0;
         end
      endcase
   endfunction

   // low result offset to slot; thermistor has no high byte mapped, so no pair
   function automatic logic [3:0] adcar_low_slot(input logic [7:0] addr);
      unique case (addr)
         ADCAR_OFF_CHG_LO: begin
            adcar_low_slot = {1'b1, SLOT_CHARGE};
         end
         ADCAR_OFF_AUX_LO: begin
            adcar_low_slot = {1'b1, SLOT_AUX};
         end
         ADCAR_OFF_VIN_LO: begin
            adcar_low_slot = {1'b1, SLOT_VIN};
         end
         ADCAR_OFF_SYS_LO: begin
            adcar_low_slot = {1'b1, SLOT_SYS};
         end
         ADCAR_OFF_IIN_LO: begin
            adcar_low_slot = {1'b1, SLOT_IIN};
         end
         default: begin
            adcar_low_slot = 4'h0;
         end
      endcase
   endfunction

   always_comb begin
      next_state = state;
      {slot_hit, slot_sel} = adcar_slot(conv_channel);
      read_byte = ADCAR_READ_UNMAPPED;

      // one 16-bit write keeps both bytes of a slot from the same sample
      if (conv_valid && slot_hit) begin
         next_state.result[slot_sel] = conv_data;
      end

      // read decode; results are read-only, unmapped reads return zero
      unique case (reg_addr)
         ADCAR_OFF_THERM_LO: begin
            read_byte = state.result[SLOT_THERM][7:0];
         end
         ADCAR_OFF_CHG_HI: begin
            read_byte = state.result[SLOT_CHARGE][15:8];
         end
         ADCAR_OFF_CHG_LO: begin
            read_byte = state.result[SLOT_CHARGE][7:0];
         end
         ADCAR_OFF_AUX_HI: begin
            read_byte = state.result[SLOT_AUX][15:8];
         end
         ADCAR_OFF_AUX_LO: begin
            read_byte = state.result[SLOT_AUX][7:0];
         end
         ADCAR_OFF_VIN_HI: begin
            read_byte = state.result[SLOT_VIN][15:8];
         end
         ADCAR_OFF_VIN_LO: begin
            read_byte = state.result[SLOT_VIN][7:0];
         end
         ADCAR_OFF_SYS_HI: begin
            read_byte = state.result[SLOT_SYS][15:8];
         end
         ADCAR_OFF_SYS_LO: begin
            read_byte = state.result[SLOT_SYS][7:0];
         end
         ADCAR_OFF_IIN_HI: begin
            read_byte = state.result[SLOT_IIN][15:8];
         end
         ADCAR_OFF_IIN_LO: begin
            read_byte = state.result[SLOT_IIN][7:0];
         end
         ADCAR_OFF_ALM1_HI: begin
            read_byte = state.alarm1_threshold_high;
         end
         ADCAR_OFF_ALM1_LO: begin
            read_byte = state.alarm1_threshold_low_polarity;
         end
         ADCAR_OFF_ALM2_HI: begin
            read_byte = state.alarm2_threshold_high;
         end
         ADCAR_OFF_ALM2_LO: begin
            read_byte = state.alarm2_threshold_low_polarity;
         end
         default: begin
            read_byte = ADCAR_READ_UNMAPPED;
         end
      endcase

      // a high-byte read parks its low byte, so a conversion landing
      // between the two reads cannot tear the pair
      {hi_hit, hi_slot} = adcar_high_slot(reg_addr);
      {lo_hit, lo_slot} = adcar_low_slot(reg_addr);
      if (reg_rd) begin
         next_state.shadow_valid = hi_hit;
         if (hi_hit) begin
            next_state.shadow_slot = hi_slot;
            next_state.shadow_low  = state.result[hi_slot][7:0];
         end
         if (lo_hit && state.shadow_valid && (state.shadow_slot == lo_slot)) begin
            read_byte = state.shadow_low;
         end
      end

      next_state.rvalid = reg_rd;
      if (reg_rd) begin
         next_state.rdata = read_byte;
      end

      // writes land only on the threshold bytes; result offsets ignore them
      if (reg_wr) begin
         unique case (reg_addr)
            ADCAR_OFF_ALM1_HI: begin
               next_state.alarm1_threshold_high = reg_wdata;
            end
            ADCAR_OFF_ALM1_LO: begin
               next_state.alarm1_threshold_low_polarity = reg_wdata;
            end
            ADCAR_OFF_ALM2_HI: begin
               next_state.alarm2_threshold_high = reg_wdata;
            end
            ADCAR_OFF_ALM2_LO: begin
               next_state.alarm2_threshold_low_polarity = reg_wdata;
            end
            default: ;
         endcase
      end

      // completion clears the trigger, but a new request in that cycle wins
      if (conv_valid) begin
         next_state.trigger = 1'b0;
      end
      if (trigger_set) begin
         next_state.trigger = 1'b1;
      end

      // sticky alarm flags; a trip in the clearing cycle is kept
      if (alarm1_flag_clear) begin
         next_state.flag1 = 1'b0;
      end
      if (cmp1_event) begin
         next_state.flag1 = 1'b1;
      end
      if (alarm2_flag_clear) begin
         next_state.flag2 = 1'b0;
      end
      if (cmp2_event) begin
         next_state.flag2 = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state.result                        <= {(NUM_SLOTS * 2){ADCAR_RST_RESULT}};
         state.alarm1_threshold_high         <= ADCAR_RST_ALM1_HI;
         state.alarm1_threshold_low_polarity <= ADCAR_RST_ALM1_LO;
         state.alarm2_threshold_high         <= ADCAR_RST_ALM2_HI;
         state.alarm2_threshold_low_polarity <= ADCAR_RST_ALM2_LO;
         state.rdata                         <= ADCAR_RST_RESULT;
         state.rvalid                        <= 1'b0;
         state.trigger                       <= 1'b0;
         state.flag1                         <= 1'b0;
         state.flag2                         <= 1'b0;
         state.shadow_low                    <= ADCAR_RST_RESULT;
         state.shadow_slot                   <= SLOT_THERM;
         state.shadow_valid                  <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   adcar_alarm_cmp u_alarm1 (
      .clk            (clk),
      .rstn           (rstn),
      .conv_valid     (conv_valid),
      .conv_channel   (conv_channel),
      .conv_data      (conv_data),
      .channel_select (alarm1_channel_select),
      .threshold      (adcar_threshold(state.alarm1_threshold_high,
                                       state.alarm1_threshold_low_polarity)),
      .direction      (state.alarm1_threshold_low_polarity[ADCAR_DIR_BIT]),
      .alarm_event    (cmp1_event)
   );

   adcar_alarm_cmp u_alarm2 (
      .clk            (clk),
      .rstn           (rstn),
      .conv_valid     (conv_valid),
      .conv_channel   (conv_channel),
      .conv_data      (conv_data),
      .channel_select (alarm2_channel_select),
      .threshold      (adcar_threshold(state.alarm2_threshold_high,
                                       state.alarm2_threshold_low_polarity)),
      .direction      (state.alarm2_threshold_low_polarity[ADCAR_DIR_BIT]),
      .alarm_event    (cmp2_event)
   );

   assign reg_rdata          = state.rdata;
   assign reg_rvalid         = state.rvalid;
   assign conversion_trigger = state.trigger;
   assign alarm1_event       = cmp1_event;
   assign alarm2_event       = cmp2_event;
   assign alarm1_flag        = state.flag1;
   assign alarm2_flag        = state.flag2;
   assign alarm1_threshold   = adcar_threshold(state.alarm1_threshold_high,
                                               state.alarm1_threshold_low_polarity);
   assign alarm2_threshold   = adcar_threshold(state.alarm2_threshold_high,
                                               state.alarm2_threshold_low_polarity);
   assign alarm1_direction   = state.alarm1_threshold_low_polarity[ADCAR_DIR_BIT];
   assign alarm2_direction   = state.alarm2_threshold_low_polarity[ADCAR_DIR_BIT];

endmodule

// file: test/adcar_regs_asserts.sv
`timescale 1ns/1ps

module adcar_regs_asserts
   import adcar_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        conv_valid,
   input wire logic [2:0]  conv_channel,
   input wire logic [15:0] conv_data,
   input wire logic        trigger_set,
   input wire logic        conversion_trigger,
   input wire logic [2:0]  alarm1_channel_select,
   input wire logic [2:0]  alarm2_channel_select,
   input wire logic        alarm1_event,
   input wire logic        alarm2_event,
   input wire logic        alarm1_flag,
   input wire logic [11:0] alarm1_threshold,
   input wire logic [11:0] alarm2_threshold,
   input wire logic        alarm1_direction,
   input wire logic        alarm2_direction
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // plain read with no write in the same cycle, so the old value is expected
   sequence s_rd(a);
      reg_rd && !reg_wr && reg_addr == a;
   endsequence

   // alarm 1 trip: event one cycle after the conversion, sticky flag the cycle after
   sequence s_trip1;
      alarm1_event ##1 alarm1_flag;
   endsequence

   a_read_answered: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered one cycle later");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read valid without a read request");
   a_thr1_hi_read: assert property (s_rd(ADCAR_OFF_ALM1_HI)
      |=> reg_rdata == $past(alarm1_threshold[11:4]))
      else $error("alarm 1 high byte read wrong");
   a_thr1_lo_read: assert property (s_rd(ADCAR_OFF_ALM1_LO)
      |=> reg_rdata[7:3] == $past({alarm1_threshold[3:0], alarm1_direction}))
      else $error("alarm 1 low byte read wrong");
   a_thr2_lo_read: assert property (s_rd(ADCAR_OFF_ALM2_LO)
      |=> reg_rdata[7:3] == $past({alarm2_threshold[3:0], alarm2_direction}))
      else $error("alarm 2 low byte read wrong");
   a_thr2_hi_write: assert property (reg_wr && reg_addr == ADCAR_OFF_ALM2_HI
      |=> alarm2_threshold[11:4] == $past(reg_wdata))
      else $error("alarm 2 high byte write lost");
   a_below_trip: assert property (conv_valid && alarm1_channel_select != 3'h0
      && !alarm1_direction && conv_channel == alarm1_channel_select
      && conv_data[15:4] < alarm1_threshold |=> s_trip1)
      else $error("alarm 1 did not trip below threshold");
   a_above_trip: assert property (conv_valid && alarm2_channel_select != 3'h0
      && alarm2_direction && conv_channel == alarm2_channel_select
      && conv_data[15:4] > alarm2_threshold |=> alarm2_event)
      else $error("alarm 2 did not trip above threshold");
   a_off_quiet: assert property (conv_valid && alarm1_channel_select == 3'h0
      |=> !alarm1_event)
      else $error("disabled alarm 1 tripped");
   a_event_cause: assert property (alarm2_event |-> $past(conv_valid))
      else $error("alarm 2 event without a conversion");
   a_trig_clear: assert property (conv_valid && !trigger_set |=> !conversion_trigger)
      else $error("conversion trigger not cleared");
endmodule

bind adcar_regs adcar_regs_asserts adcar_regs_asserts_i (
   .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_valid(conv_valid),
   .conv_channel(conv_channel), .conv_data(conv_data), .trigger_set(trigger_set),
   .conversion_trigger(conversion_trigger), .alarm1_channel_select(alarm1_channel_select),
   .alarm2_channel_select(alarm2_channel_select), .alarm1_event(alarm1_event),
   .alarm2_event(alarm2_event), .alarm1_flag(alarm1_flag), .alarm1_threshold(alarm1_threshold),
   .alarm2_threshold(alarm2_threshold), .alarm1_direction(alarm1_direction),
   .alarm2_direction(alarm2_direction));

// file: test/adcar_regs_tb.sv
`timescale 1ns/1ps

module adcar_regs_tb
   import adcar_pkg::*;
;
   logic        clk, rstn, reg_wr, reg_rd, reg_rvalid, conv_valid, trigger_set, conversion_trigger;
   logic        clr1, clr2, alarm1_event, alarm2_event, alarm1_flag, alarm2_flag;
   logic        alarm1_direction, alarm2_direction;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [2:0]  conv_channel, sel1, sel2;
   logic [15:0] conv_data;
   logic [11:0] alarm1_threshold, alarm2_threshold;
   int          fails, checks_done;

   adcar_regs adcar_regs_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
      .trigger_set(trigger_set), .conversion_trigger(conversion_trigger),
      .alarm1_channel_select(sel1), .alarm2_channel_select(sel2), .alarm1_flag_clear(clr1),
      .alarm2_flag_clear(clr2), .alarm1_event(alarm1_event), .alarm2_event(alarm2_event),
      .alarm1_flag(alarm1_flag), .alarm2_flag(alarm2_flag), .alarm1_threshold(alarm1_threshold),
      .alarm2_threshold(alarm2_threshold), .alarm1_direction(alarm1_direction),
      .alarm2_direction(alarm2_direction));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // answer lands one cycle after the request edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check(reg_rvalid, 1'b1);
      check(reg_rdata, exp);
   endtask

   task automatic cv(input logic [2:0] ch, input logic [15:0] d, input logic e1, input logic e2);
      @(negedge clk);
      conv_channel = ch;
      conv_data = d;
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
      check(alarm1_event, e1);
      check(alarm2_event, e2);
   endtask

   task automatic t_reset;
      check(alarm1_threshold, 12'h232);
      check(alarm2_threshold, 12'h389);
      check({alarm1_direction, alarm2_direction}, 2'h0);
      rd(ADCAR_OFF_ALM1_HI, 8'h23);
      rd(ADCAR_OFF_ALM1_LO, 8'h20);
      rd(ADCAR_OFF_ALM2_HI, 8'h38);
      rd(ADCAR_OFF_ALM2_LO, 8'h90);
      rd(8'h50, ADCAR_READ_UNMAPPED);
   endtask

   // writes to every result byte except the thermistor low byte must bounce off
   task automatic t_results;
      logic [2:0] ch [5] = '{3'h4, 3'h1, 3'h5, 3'h6, 3'h7};
      logic [7:0] hi [5] = '{8'h46, 8'h48, 8'h4A, 8'h4C, 8'h4E};
      for (int i = 0; i < 5; i++) begin
         cv(ch[i], {~hi[i], hi[i]}, 1'b0, 1'b0);
         wr(hi[i], 8'h00);
         wr(hi[i] + 8'h01, 8'h00);
         rd(hi[i], ~hi[i]);
         rd(hi[i] + 8'h01, hi[i]);
      end
      // a conversion between the high and low reads must not tear the pair
      rd(ADCAR_OFF_VIN_HI, 8'hB5);
      cv(3'h5, 16'h1234, 1'b0, 1'b0);
      rd(ADCAR_OFF_VIN_LO, 8'h4A);
      rd(ADCAR_OFF_VIN_LO, 8'h34);
      cv(3'h2, 16'h5A3C, 1'b0, 1'b0);
      rd(ADCAR_OFF_THERM_LO, 8'h3C);
   endtask

   task automatic t_alarm;
      sel1 = ADCAR_CH_CHARGE;
      sel2 = ADCAR_CH_VIN;
      cv(3'h4, 16'h2310, 1'b1, 1'b0);
      // the sticky flag follows the event by one cycle
      @(negedge clk);
      check(alarm1_flag, 1'b1);
      cv(3'h4, 16'h2320, 1'b0, 1'b0);
      cv(3'h5, 16'h2310, 1'b0, 1'b1);
      @(negedge clk);
      check(alarm2_flag, 1'b1);
      wr(ADCAR_OFF_ALM2_LO, 8'h98);
      check(alarm2_direction, 1'b1);
      // clear held across a trip: the set wins
      clr2 = 1'b1;
      cv(3'h5, 16'h38A0, 1'b0, 1'b1);
      @(negedge clk);
      clr2 = 1'b0;
      check(alarm2_flag, 1'b1);
      cv(3'h5, 16'h3880, 1'b0, 1'b0);
      @(negedge clk);
      {clr1, clr2} = 2'h3;
      @(negedge clk);
      {clr1, clr2} = 2'h0;
      check(alarm1_flag, 1'b0);
      check(alarm2_flag, 1'b0);
      for (int k = 1; k < 8; k++) begin
         sel1 = k[2:0];
         cv(k[2:0], 16'h0000, 1'b1, 1'b0);
      end
      sel1 = ADCAR_CH_OFF;
      cv(3'h4, 16'h0000, 1'b0, 1'b0);
   endtask

   task automatic t_thresh;
      wr(ADCAR_OFF_ALM1_LO, 8'h58);
      check(alarm1_threshold, 12'h235);
      check(alarm1_direction, 1'b1);
      wr(ADCAR_OFF_ALM1_HI, 8'hC4);
      rd(ADCAR_OFF_ALM1_HI, 8'hC4);
      rd(ADCAR_OFF_ALM1_LO, 8'h58);
      wr(ADCAR_OFF_ALM2_HI, 8'h7E);
      check(alarm2_threshold, 12'h7E9);
      sel1 = ADCAR_CH_CHARGE;
      cv(3'h4, 16'hC460, 1'b1, 1'b0);
   endtask

   // reset in mid-run must restore the thresholds written above
   task automatic t_rereset;
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      check(alarm1_threshold, 12'h232);
      check({alarm1_direction, alarm2_direction, alarm1_flag}, 3'h0);
      rstn = 1'b1;
      check(alarm2_threshold, 12'h389);
      rd(ADCAR_OFF_ALM2_LO, 8'h90);
   endtask

   task automatic t_trigger;
      @(negedge clk);
      trigger_set = 1'b1;
      @(negedge clk);
      trigger_set = 1'b0;
      check(conversion_trigger, 1'b1);
      cv(3'h1, 16'h0000, 1'b0, 1'b0);
      check(conversion_trigger, 1'b0);
   endtask

   // hang guard: a run that overstays counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      tally_and_finish;
   end

   initial begin
      {rstn, reg_wr, reg_rd, conv_valid, trigger_set, clr1, clr2} = 7'h00;
      {reg_addr, reg_wdata, conv_channel, sel1, sel2, conv_data} = 41'h0;
      fails = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      t_reset;
      t_results;
      t_alarm;
      t_thresh;
      t_rereset;
      t_trigger;
      tally_and_finish;
   end
endmodule
